// file: rtl/fault_pkg.sv
// Constants, register map and types of the fault supervisor.
// Assumes one 50 MHz core clock and an APB master with 32-bit data.
//
// Functional notes
// - Idle and ready without error: LED blinks slowly, every two seconds.
// - Firing normally without fault: LED blinks fast, once every 0.6 s.
// - Programming mode is shown as a group of six flashes.
// - After power cycle following an error: one flash, then dark, ready.
// - Faulty pickup signal stops ignition, latches error, two-flash group.
// - Speed below 60 crank or 30 cam revs: error, three-flash group.
// - Start/stop mode, release not opened at start: blocked, three flashes.
// - Speed above overspeed limit: shutdown, latch error, four-flash group.
// - Supply voltage too low: error state, five-flash group.
// - Open primary circuit misfires are counted over a one second window.
// - Misfire rate above limit: shutdown, latch error, six-flash group.
// - Release closed over security speed: blocked till stop, six flashes.
// - Start/stop input acts as external shutdown contact stopping ignition.
// - Error persists until host reset command or power removal.
package fault_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int SLOW_MS = 2000;
   localparam int FAST_MS = 600;
   localparam int WINDOW_MS = 1000;
   localparam logic [4:0] SLOW_TICKS = 5'(SLOW_MS / TICK_MS);
   localparam logic [4:0] FAST_TICKS = 5'(FAST_MS / TICK_MS);
   localparam logic [4:0] WINDOW_TICKS = 5'(WINDOW_MS / TICK_MS);
   localparam logic [4:0] FLASH_ON_TICKS = 5'h01;
   localparam logic [4:0] FLASH_GAP_TICKS = 5'h02;
   localparam logic [4:0] PAUSE_TICKS = 5'h0A;

   // ----------------------------------------------------------------
   // Speed thresholds and flash counts
   // ----------------------------------------------------------------
   localparam logic [15:0] MIN_CRANK_RPM = 16'd60;
   localparam logic [15:0] MIN_CAM_RPM = 16'd30;
   localparam logic [2:0] FL_PICKUP = 3'h2;
   localparam logic [2:0] FL_SLOW = 3'h3;
   localparam logic [2:0] FL_OVERSPEED = 3'h4;
   localparam logic [2:0] FL_VOLT = 3'h5;
   localparam logic [2:0] FL_SIX = 3'h6;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] OVERSPEED_OFS = 8'h04;
   localparam logic [7:0] SECURITY_OFS = 8'h08;
   localparam logic [7:0] MISLIMIT_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQSTAT_OFS = 8'h14;
   localparam logic [7:0] IRQMASK_OFS = 8'h18;
   localparam int CTRL_SS_BIT = 0;
   localparam int CTRL_CAM_BIT = 1;
   localparam int CTRL_PROG_BIT = 2;
   localparam int CTRL_RESET_BIT = 3;
   localparam logic [2:0] CTRL_RST_VAL = 3'h0;
   localparam logic [15:0] OVERSPEED_RST_VAL = 16'hFFFF;
   localparam logic [15:0] SECURITY_RST_VAL = 16'hFFFF;
   localparam logic [15:0] MISLIMIT_RST_VAL = 16'hFFFF;
   localparam logic [3:0] IRQ_RST_VAL = 4'h0;

   // LED patterns requested from the coder
   typedef enum logic [2:0] {
      PAT_DARK = 3'h0,
      PAT_SLOW = 3'h1,
      PAT_FAST = 3'h2,
      PAT_GROUP = 3'h3,
      PAT_SINGLE = 3'h4
   } pattern_e;

   // Supervisor states, one-hot
   typedef enum logic [4:0] {
      ST_READY = 5'b00001,
      ST_RUN = 5'b00010,
      ST_ERROR = 5'b00100,
      ST_BLOCKED = 5'b01000,
      ST_WAITSTOP = 5'b10000
   } sup_state_e;

endpackage

// file: rtl/fault_supervisor.sv
// Fault supervisor: latches ignition errors, gates ignition, APB regs.
// Assumes engine speed, pickup and misfire inputs come from core-clock
// logic; the release contact and low-voltage comparator are pins.
`timescale 1ns/1ns
`default_nettype none
module fault_supervisor import fault_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] engineSpeed,
   input wire logic engineStopped,
   input wire logic pickupFault,
   input wire logic primaryOpen,
   input wire logic lowVoltagePin,
   input wire logic releaseClosedPin,
   input wire logic errorAtPowerDown,
   output logic ignitionEnable,
   output logic statusLed,
   output logic irq
);

   flash_if fl();
   sup_state_e state_r, state_nxt;
   logic [2:0] ctrl_r;
   logic [15:0] overspeed_r, security_r, misLimit_r;
   logic [3:0] irqStat_r, irqMask_r, events;
   logic [2:0] errCode_r, detCode;
   logic [31:0] tickCnt_r;
   logic [4:0] winCnt_r;
   logic [15:0] misCnt_r;
   logic [1:0] lowSync_r, relSync_r;
   logic powerRestored_r, startSeen_r, ignEn_r, errReset;
   logic relClosed_d_r, errDet, wrEn, mapped;
   logic ssMode, lowVolt, relClosed;

   assign ssMode = ctrl_r[CTRL_SS_BIT];
   assign lowVolt = lowSync_r[1];
   assign relClosed = relSync_r[1];

   // ----------------------------------------------------------------
   // Pin synchronisers and time base
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lowSync_r <= 2'b00;
         relSync_r <= 2'b00;
      end else begin
         lowSync_r <= {lowSync_r[0], lowVoltagePin};
         relSync_r <= {relSync_r[0], releaseClosedPin};
      end
   end

   // 100 ms tick for LED timing and the misfire window
   always_ff @(posedge core_clk) begin
      if (rst || tickCnt_r == 32'(TICK_CYCLES - 1)) begin
         tickCnt_r <= 32'h0;
      end else begin
         tickCnt_r <= tickCnt_r + 32'h1;
      end
   end
   assign fl.tick = (tickCnt_r == 32'(TICK_CYCLES - 1));

   // ----------------------------------------------------------------
   // Misfire rate over a one second window
   // ----------------------------------------------------------------
   // count open-primary misfires
   always_ff @(posedge core_clk) begin
      if (rst) begin
         winCnt_r <= 5'h00;
         misCnt_r <= 16'h0;
      end else if (fl.tick && winCnt_r == WINDOW_TICKS - 5'h01) begin
         winCnt_r <= 5'h00;
         misCnt_r <= 16'(primaryOpen);
      end else begin
         if (fl.tick) begin
            winCnt_r <= winCnt_r + 5'h01;
         end
         if (primaryOpen && misCnt_r != 16'hFFFF) begin
            misCnt_r <= misCnt_r + 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Fault detection, fixed priority within one cycle
   // ----------------------------------------------------------------
   always_comb begin
      detCode = 3'h0;
      if (pickupFault) begin
         detCode = FL_PICKUP;
      end else if (!engineStopped && state_r == ST_RUN &&
                   engineSpeed < (ctrl_r[CTRL_CAM_BIT] ?
                                  MIN_CAM_RPM : MIN_CRANK_RPM)) begin
         detCode = FL_SLOW;
      end else if (engineSpeed > overspeed_r) begin
         detCode = FL_OVERSPEED;
      end else if (lowVolt) begin
         detCode = FL_VOLT;
      end else if (misCnt_r > misLimit_r) begin
         detCode = FL_SIX;
      end
   end
   assign errDet = (detCode != 3'h0);

   // ----------------------------------------------------------------
   // Supervisor state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_READY: begin
            if (errDet) begin
               state_nxt = ST_ERROR;
            end else if (!engineStopped) begin
               state_nxt = (ssMode && relClosed) ? ST_BLOCKED : ST_RUN;
            end
         end
         ST_RUN: begin
            if (errDet) begin
               state_nxt = ST_ERROR;
            end else if (engineStopped) begin
               state_nxt = ST_READY;
            end else if (ssMode && relClosed && !relClosed_d_r &&
                         engineSpeed > security_r) begin
               state_nxt = ST_WAITSTOP;
            end
         end
         ST_BLOCKED, ST_WAITSTOP: begin
            if (errDet) begin
               state_nxt = ST_ERROR;
            end else if (engineStopped) begin
               state_nxt = ST_READY;
            end
         end
         // only the host reset leaves the error state
         ST_ERROR: begin
            if (errReset) begin
               state_nxt = ST_READY;
            end
         end
         default: state_nxt = ST_READY;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ST_READY;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         errCode_r <= 3'h0;
      end else if (state_r == ST_ERROR) begin
         if (errReset) begin
            errCode_r <= 3'h0;
         end
      end else if (errDet) begin
         errCode_r <= detCode;
      end
   end

   // Power-down strap caught one edge after reset release
   always_ff @(posedge core_clk) begin
      if (rst) begin
         startSeen_r <= 1'b0;
         powerRestored_r <= 1'b0;
      end else begin
         startSeen_r <= 1'b1;
         // flag a restart that cleared an error
         if (!startSeen_r) begin
            powerRestored_r <= errorAtPowerDown;
         end else if (state_r != ST_READY) begin
            powerRestored_r <= 1'b0;
         end
      end
   end

   // Ignition gate, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ignEn_r <= 1'b0;
      end else begin
         ignEn_r <= (state_nxt == ST_RUN) && !(ssMode && relClosed);
      end
   end
   assign ignitionEnable = ignEn_r;

   // ----------------------------------------------------------------
   // LED pattern selection
   // ----------------------------------------------------------------
   always_comb begin
      fl.pattern = PAT_SLOW;
      fl.count = 3'h0;
      case (state_r)
         ST_ERROR: begin
            fl.pattern = PAT_GROUP;
            fl.count = errCode_r;
         end
         ST_BLOCKED: begin
            fl.pattern = PAT_GROUP;
            fl.count = FL_SLOW;
         end
         ST_WAITSTOP: begin
            fl.pattern = PAT_GROUP;
            fl.count = FL_SIX;
         end
         ST_RUN: fl.pattern = PAT_FAST;
         default: begin
            if (ctrl_r[CTRL_PROG_BIT]) begin
               fl.pattern = PAT_GROUP;
               fl.count = FL_SIX;
            end else if (powerRestored_r) begin
               fl.pattern = PAT_SINGLE;
            end
         end
      endcase
   end

   led_flash_coder coder (
      .core_clk(core_clk),
      .rst(rst),
      .fl(fl.coder)
   );
   assign statusLed = fl.led;

   // ----------------------------------------------------------------
   // APB slave and interrupts
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign wrEn = psel && penable && pwrite;
   assign mapped = (paddr == CTRL_OFS) || (paddr == OVERSPEED_OFS) ||
                   (paddr == SECURITY_OFS) || (paddr == MISLIMIT_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == IRQSTAT_OFS) ||
                   (paddr == IRQMASK_OFS);
   assign pslverr = psel && penable && !mapped;
   // reset-errors command arrives as a write-one bit
   assign errReset = wrEn && paddr == CTRL_OFS && pwdata[CTRL_RESET_BIT];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_r <= CTRL_RST_VAL;
         overspeed_r <= OVERSPEED_RST_VAL;
         security_r <= SECURITY_RST_VAL;
         misLimit_r <= MISLIMIT_RST_VAL;
         irqMask_r <= IRQ_RST_VAL;
      end else if (wrEn) begin
         case (paddr)
            CTRL_OFS: ctrl_r <= pwdata[2:0];
            OVERSPEED_OFS: overspeed_r <= pwdata[15:0];
            SECURITY_OFS: security_r <= pwdata[15:0];
            MISLIMIT_OFS: misLimit_r <= pwdata[15:0];
            IRQMASK_OFS: irqMask_r <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         case (paddr)
            CTRL_OFS: prdata <= {29'h0, ctrl_r};
            OVERSPEED_OFS: prdata <= {16'h0, overspeed_r};
            SECURITY_OFS: prdata <= {16'h0, security_r};
            MISLIMIT_OFS: prdata <= {16'h0, misLimit_r};
            STATUS_OFS: prdata <= {20'h0, misCnt_r[7:0], ignEn_r,
                                   errCode_r};
            IRQSTAT_OFS: prdata <= {28'h0, irqStat_r};
            IRQMASK_OFS: prdata <= {28'h0, irqMask_r};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // Contact one cycle back; resets to the open level, so no false edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         relClosed_d_r <= 1'b0;
      end else begin
         relClosed_d_r <= relClosed;
      end
   end

   // Events: error entry, blocked, wait-stop, misfire seen
   assign events = {primaryOpen,
                    state_nxt == ST_WAITSTOP && state_r != ST_WAITSTOP,
                    state_nxt == ST_BLOCKED && state_r != ST_BLOCKED,
                    state_nxt == ST_ERROR && state_r != ST_ERROR};

   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqStat_r <= IRQ_RST_VAL;
      end else begin
         irqStat_r <= events | (irqStat_r &
                      ~((wrEn && paddr == IRQSTAT_OFS) ? pwdata[3:0] : 4'h0));
      end
   end
   assign irq = |(irqStat_r & irqMask_r);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence err_entered;
      state_r != ST_ERROR ##1 state_r == ST_ERROR;
   endsequence

   error_hold_a: assert property (
      state_r == ST_ERROR && !errReset |=> state_r == ST_ERROR)
      else $error("Error state left without reset");
   reset_exit_a: assert property (
      state_r == ST_ERROR && errReset |=> state_r == ST_READY)
      else $error("Reset did not clear error");
   pickup_stop_a: assert property (
      pickupFault && state_r != ST_ERROR |=> state_r == ST_ERROR &&
      errCode_r == FL_PICKUP ##1 !ignEn_r)
      else $error("Pickup fault not latched");
   overspeed_stop_a: assert property (
      engineSpeed > overspeed_r |=> !ignEn_r)
      else $error("Ignition on above overspeed");
   volt_code_a: assert property (
      lowVolt && !pickupFault && engineSpeed <= overspeed_r &&
      engineSpeed >= MIN_CRANK_RPM &&
      (state_r == ST_READY || state_r == ST_RUN) |=> errCode_r == FL_VOLT)
      else $error("Low voltage code wrong");
   first_code_a: assert property (
      err_entered ##0 !errReset |=> $stable(errCode_r) &&
      state_r == ST_ERROR)
      else $error("Latched code changed");
   contact_stop_a: assert property (
      ssMode && relClosed |=> !ignEn_r)
      else $error("Ignition on with contact closed");
   waitstop_hold_a: assert property (
      state_r == ST_WAITSTOP && !engineStopped && !errDet
      |=> state_r == ST_WAITSTOP ##0 fl.count == FL_SIX)
      else $error("Wait-stop released early");
   blocked_start_a: assert property (
      state_r == ST_READY && !engineStopped && ssMode && relClosed &&
      !errDet |=> state_r == ST_BLOCKED ##1 !ignEn_r)
      else $error("Start with closed release not blocked");
   misfire_err_a: assert property (
      misCnt_r > misLimit_r && state_r == ST_RUN |=> state_r == ST_ERROR)
      else $error("Misfire rate not latched");
   run_fast_a: assert property (
      state_r == ST_RUN |-> fl.pattern == PAT_FAST)
      else $error("Run state not fast blink");

endmodule
`default_nettype wire

// file: rtl/flash_if.sv
// Pattern request and LED level between supervisor and flash coder.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface flash_if;
   import fault_pkg::*;
   pattern_e pattern;
   logic [2:0] count;
   logic tick;
   logic led;
   modport src (output pattern, output count, output tick, input led);
   modport coder (input pattern, input count, input tick, output led);
endinterface
`default_nettype wire

// file: rtl/led_flash_coder.sv
// Status LED flash coder: blink rates, flash groups and single flash.
// Assumes a one-cycle tick enable every 100 ms from the supervisor.
`timescale 1ns/1ns
`default_nettype none
module led_flash_coder import fault_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   flash_if.coder fl
);

   logic [4:0] phase_r;
   logic [2:0] flashNo_r;
   logic single_r;
   logic led_r;
   pattern_e lastPat_r;
   logic [4:0] period;

   // Period of the current repeating pattern
   always_comb begin
      case (fl.pattern)
         PAT_SLOW: period = SLOW_TICKS;
         PAT_FAST: period = FAST_TICKS;
         default: period = FLASH_ON_TICKS + FLASH_GAP_TICKS;
      endcase
   end

   // ----------------------------------------------------------------
   // Pattern sequencer
   // ----------------------------------------------------------------
   // Restart on a pattern change; a count change within PAT_GROUP keeps the current group running
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_r <= 5'h00;
         flashNo_r <= 3'h0;
         single_r <= 1'b0;
         lastPat_r <= PAT_DARK;
      end else if (fl.pattern != lastPat_r) begin
         lastPat_r <= fl.pattern;
         phase_r <= 5'h00;
         flashNo_r <= 3'h0;
         single_r <= 1'b0;
      end else if (fl.tick) begin
         if (fl.pattern == PAT_GROUP && flashNo_r == fl.count) begin
            if (phase_r == PAUSE_TICKS - 5'h01) begin
               phase_r <= 5'h00;
               flashNo_r <= 3'h0;
            end else begin
               phase_r <= phase_r + 5'h01;
            end
         end else if (phase_r == period - 5'h01) begin
            phase_r <= 5'h00;
            if (fl.pattern == PAT_GROUP) begin
               flashNo_r <= flashNo_r + 3'h1;
            end
            if (fl.pattern == PAT_SINGLE) begin
               single_r <= 1'b1;
            end
         end else begin
            phase_r <= phase_r + 5'h01;
         end
      end
   end

   // LED level, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         led_r <= 1'b0;
      end else begin
         case (fl.pattern)
            PAT_SLOW, PAT_FAST: led_r <= (phase_r < FLASH_ON_TICKS);
            PAT_GROUP: led_r <= (flashNo_r != fl.count) &&
                                (phase_r < FLASH_ON_TICKS);
            PAT_SINGLE: led_r <= !single_r && (phase_r < FLASH_ON_TICKS);
            default: led_r <= 1'b0;
         endcase
      end
   end

   assign fl.led = led_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   single_dark_a: assert property (
      single_r && fl.pattern == PAT_SINGLE && lastPat_r == PAT_SINGLE
      |=> !led_r) else $error("LED lit after single flash");
   group_pause_a: assert property (
      fl.pattern == PAT_GROUP && lastPat_r == PAT_GROUP &&
      flashNo_r == fl.count |=> !led_r) else $error("LED lit in pause");

endmodule
`default_nettype wire

// file: tb/fault_supervisor_led_coder_tb.sv
// Bench for the fault supervisor: APB host, fault inputs, LED codes.
// Assumes a 10-cycle tick so every flash code fits a short run.
`timescale 1ns/1ns
`default_nettype none
module fault_supervisor_led_coder_tb import fault_pkg::*;;
   typedef struct {
      logic [2:0] ctrl;
      logic [15:0] spd;
      logic pu;
      logic lv;
      logic mf;
      logic [2:0] code;
   } row_s;
   row_s rows[6] = '{'{3'h0, 16'h03E8, 1'h1, 1'h0, 1'h0, FL_PICKUP},
      '{3'h0, 16'h003B, 1'h0, 1'h0, 1'h0, FL_SLOW},
      '{3'h2, 16'h001D, 1'h0, 1'h0, 1'h0, FL_SLOW},
      '{3'h0, 16'h07D1, 1'h0, 1'h0, 1'h0, FL_OVERSPEED},
      '{3'h0, 16'h03E8, 1'h0, 1'h1, 1'h0, FL_VOLT},
      '{3'h0, 16'h03E8, 1'h0, 1'h0, 1'h1, FL_SIX}};
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, ignitionEnable, statusLed, irq;
   logic [15:0] engineSpeed = 16'h0000;
   logic engineStopped = 1'h1, pickupFault = 1'h0, primaryOpen = 1'h0;
   logic lowVoltagePin = 1'h0, releaseClosedPin = 1'h0;
   logic errorAtPowerDown = 1'h0;
   int errors = 0, check_count = 0, cyc = 0, period, groupLen, rises, r0;

   initial forever #10 core_clk = ~core_clk;
   fault_supervisor #(.TICK_CYCLES(10)) i_fault_supervisor (.core_clk,
      .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .engineSpeed, .engineStopped, .pickupFault, .primaryOpen,
      .lowVoltagePin, .releaseClosedPin, .errorAtPowerDown,
      .ignitionEnable, .statusLed, .irq);
   led_watch i_led_watch (.core_clk, .statusLed, .period, .groupLen,
      .rises);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Holds the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Stop engine, drop faults, then error reset with new mode bits
   task automatic idle(input logic [2:0] c);
      engineSpeed <= 16'h0000;
      engineStopped <= 1'h1;
      pickupFault <= 1'h0;
      lowVoltagePin <= 1'h0;
      releaseClosedPin <= 1'h0;
      wt(5);
      apb(1'h1, CTRL_OFS, {28'h0, 1'h1, c});
   endtask
   task automatic start();
      engineSpeed <= 16'h03E8;
      engineStopped <= 1'h0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Run limit well above the planned sequence
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      wt(3);
      rst <= 1'h0;
      wt(1);
      chk(ignitionEnable, 0);
      apb(1'h0, OVERSPEED_OFS, 0);
      chk(rd, 32'hFFFF);
      apb(1'h1, OVERSPEED_OFS, 32'h7D0);
      apb(1'h1, MISLIMIT_OFS, 0);
      wt(450);
      chk(period, 200);
      // Table of faults; later faults must not replace the first code
      foreach (rows[i]) begin
         idle(rows[i].ctrl);
         start();
         wt(200);
         chk(ignitionEnable, 1);
         chk(period, 60);
         engineSpeed <= rows[i].spd;
         pickupFault <= rows[i].pu;
         lowVoltagePin <= rows[i].lv;
         primaryOpen <= rows[i].mf;
         wt(1);
         primaryOpen <= 1'h0;
         wt(5);
         chk(ignitionEnable, 0);
         pickupFault <= 1'h1;
         lowVoltagePin <= 1'h1;
         wt(700);
         apb(1'h0, STATUS_OFS, 0);
         chk(32'(rd[2:0]), 32'(rows[i].code));
         chk(groupLen, 32'(rows[i].code));
      end
      // Interrupt mask, clear, unmapped place
      chk(irq, 0);
      apb(1'h1, IRQMASK_OFS, 1);
      wt(1);
      chk(irq, 1);
      apb(1'h1, IRQSTAT_OFS, 1);
      wt(1);
      chk(irq, 0);
      apb(1'h0, 8'h1C, 0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      // Slow blink first, so the six-flash check cannot pass on a stale count
      idle(3'h0);
      wt(450);
      chk(groupLen, 1);
      idle(3'h4);
      wt(700);
      chk(groupLen, 6);
      // Start/stop contact: wait-stop, then blocked restart
      apb(1'h1, SECURITY_OFS, 32'h1F4);
      idle(3'h1);
      start();
      wt(200);
      chk(ignitionEnable, 1);
      releaseClosedPin <= 1'h1;
      wt(5);
      chk(ignitionEnable, 0);
      wt(700);
      chk(groupLen, 6);
      engineSpeed <= 16'h0000;
      engineStopped <= 1'h1;
      wt(20);
      start();
      wt(700);
      chk(groupLen, 3);
      chk(32'(ignitionEnable), 32'h0);
      // Power cycle after an error: one flash, then dark
      idle(3'h0);
      errorAtPowerDown <= 1'h1;
      rst <= 1'h1;
      wt(3);
      rst <= 1'h0;
      r0 = rises;
      wt(500);
      chk(rises - r0, 1);
      chk(statusLed, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// file: tb/led_watch.sv
// LED watcher: flash period, flashes in the last group, rising edges.
// Assumes the LED is sampled on the core clock.
`timescale 1ns/1ns
`default_nettype none
module led_watch #(
   parameter int GAP = 50
) (
   input wire logic core_clk,
   input wire logic statusLed,
   output int period,
   output int groupLen,
   output int rises
);
   int gap;
   int cnt;
   logic ledD;
   // A dark gap longer than GAP closes a group
   always_ff @(posedge core_clk) begin
      ledD <= statusLed;
      gap <= gap + 1;
      if (statusLed && !ledD) begin
         period <= gap;
         gap <= 1;
         rises <= rises + 1;
         cnt <= (gap > GAP) ? 1 : cnt + 1;
         if (gap > GAP)
            groupLen <= cnt;
      end
   end
endmodule
`default_nettype wire
